// File: bench/axi_source.sv
// AXI4-Lite master standing in for the upstream sample source
`timescale 1ns/100ps
`default_nettype none
module axi_source (
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [8:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [8:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// ==========================
	// Bus cycles
	int stalls = 0;
	// Byte strobes used by the next write
	logic [3:0] strb = 4'hf;
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [8:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		r = bresp;
		bready <= 1'b0;
		if (n >= 200) stalls++;
	endtask
	task automatic rd(input logic [8:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (n >= 200) stalls++;
	endtask
endmodule
`default_nettype wire

// File: bench/signal_smoothing_lowpass_bench.sv
// Self-checking bench of the smoothing filter array
`timescale 1ns/100ps
`default_nettype none
module signal_smoothing_lowpass_bench;
	import smoothing_filter_pkg::*;
	// ==========================
	// Wiring
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [8:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [511:0] filtered_output;
	logic [15:0] raw, g, e;
	logic [15:0] raws [6] = '{16'h04d2, 16'h8000, 16'h7fff, 16'hffff, 16'hfff9, 16'h7fff};
	logic [15:0] gains [6] = '{16'h0064, 16'hffff, 16'h00c8, 16'h0032, 16'h0021, 16'h0000};
	longint y, tgt;
	int c, n;
	int miscompares = 0;
	int n_compared = 0;
	smoothing_filter_block #(.CHANNELS(32), .CYCLE_MS(1), .CYCLE_CLKS(4)) smoothing_filter_block_i (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .filtered_output);
	axi_source axi_source_i (
		.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	initial begin
		forever #12.5 aclk = ~aclk;
	end
	// ==========================
	// Checking helpers
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Scaled input as 16.16 state, clamped to the signed 32-bit state range
	function automatic longint target(input logic [15:0] x, input logic [15:0] k);
		longint q;
		q = longint'($signed(x)) * longint'(k) * 65536 / 100;
		if (q > longint'(ACC_MAX)) q = longint'(ACC_MAX);
		if (q < longint'(ACC_MIN)) q = longint'(ACC_MIN);
		return q;
	endfunction
	task automatic wait_out(input int ch, input logic [15:0] exp, input int lim);
		int k;
		k = 0;
		@(negedge aclk);
		while (filtered_output[ch*16 +: 16] !== exp && k < lim) begin
			@(negedge aclk);
			k++;
		end
		check("filtered_output", 32'(filtered_output[ch*16 +: 16]), 32'(exp));
	endtask
	// ==========================
	// Scenarios
	initial begin
		void'($urandom(32'hbd7f9047));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		check("out_reset", 32'(|filtered_output), 32'h0);
		axi_source_i.rd(9'h0f8, d, r);
		check("cfg_reset", d, CFG_RESET);
		axi_source_i.strb = 4'h3;
		axi_source_i.wr(9'h0f8, 32'haaaa_5555, r);
		axi_source_i.strb = 4'hf;
		axi_source_i.rd(9'h0f8, d, r);
		check("strb_write", d, {CFG_RESET[31:16], 16'h5555});
		axi_source_i.rd(9'h0fc, d, r);
		check("in_reset", d, 32'(IN_RESET));
		axi_source_i.rd(9'h180, d, r);
		check("unmapped_resp", 32'(r), 32'(RESP_SLVERR));
		check("unmapped_data", d, 32'h0);
		axi_source_i.wr(OUT_BASE, 32'h0000_1234, r);
		check("out_write_resp", 32'(r), 32'(RESP_SLVERR));
		axi_source_i.wr(9'h01c, 32'hfffe_8000, r);
		axi_source_i.rd(9'h01c, d, r);
		check("in_readback", d, 32'h0000_8000);
		// Corner and random gains; a zero time loads the target at every scan after the first
		for (int i = 0; i < 10; i++) begin
			raw = i < 6 ? raws[i] : 16'($urandom);
			g = i < 6 ? gains[i] : 16'($urandom_range(400));
			c = i * 3;
			axi_source_i.wr(9'(CFG_BASE + 8 * c), {g, 16'h0000}, r);
			check("cfg_resp", 32'(r), 32'(RESP_OKAY));
			axi_source_i.rd(9'(CFG_BASE + 8 * c), d, r);
			check("cfg_readback", d, {g, 16'h0000});
			axi_source_i.wr(9'(IN_BASE + 8 * c), {15'h0, 1'b1, raw}, r);
			e = 16'(target(raw, g) >>> 16);
			wait_out(c, raw, 300);
			wait_out(c, e, 300);
			axi_source_i.rd(9'(OUT_BASE + 4 * c), d, r);
			check("out_reg", d, {16'h0, e});
			axi_source_i.wr(9'(IN_BASE + 8 * c), {16'h0, raw}, r);
			wait_out(c, 16'h0, 3);
		end
		axi_source_i.wr(9'h004, 32'h0001_01f4, r);
		wait_out(0, 16'h01f4, 300);
		axi_source_i.wr(9'h004, 32'h0001_fe0c, r);
		wait_out(0, 16'hfe0c, 300);
		// Channel 0 off so the step channel alone uses the divider
		axi_source_i.wr(9'h004, 32'h0000_fe0c, r);
		wait_out(0, 16'h0, 3);
		// Step on a 10 s time: scan of 100 program cycles, ratio 0.01
		axi_source_i.wr(9'h0f0, 32'h0064_0064, r);
		axi_source_i.wr(9'h0f4, 32'h0001_0000, r);
		repeat (300) @(negedge aclk);
		axi_source_i.wr(9'h0f4, 32'h0001_2710, r);
		tgt = target(16'h2710, 16'h0064);
		y = 0;
		for (int k = 0; k < 100; k++) begin
			n = 0;
			while (filtered_output[495:480] === 16'(y >>> 16) && n < 1000) begin
				@(negedge aclk);
				n++;
			end
			y = y + (tgt - y) * 100 / 10000;
			check("step", 32'(filtered_output[495:480]), 32'(y >>> 16));
			if (k > 0) check("scan_gap", 32'(n >= 360 && n <= 440), 32'h1);
		end
		check("step_63", 32'(filtered_output[495:480] >= 16'd6200 && filtered_output[495:480] <= 16'd6450), 32'h1);
		check("bus_stalls", 32'(axi_source_i.stalls), 32'h0);
		final_report();
	end
endmodule
`default_nettype wire

// File: rtl/cycle_tick.sv
// Program cycle divider: one-cycle enable pulse every PERIOD clocks
`timescale 1ns/100ps
`default_nettype none
module cycle_tick #(
	parameter int unsigned PERIOD = 40000
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Program cycle pulse
	output var logic tick
);
	localparam int unsigned W = $clog2(PERIOD + 1);
	logic [W-1:0] cnt;

	initial begin
		if (PERIOD < 1)
			$error("cycle_tick: PERIOD must be at least 1");
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt == W'(PERIOD - 1));
			cnt <= (cnt == W'(PERIOD - 1)) ? '0 : cnt + W'(1);
		end
	end
endmodule
`default_nettype wire

// File: rtl/div_if.sv
// Interface: request and answer of the shared serial divider
`timescale 1ns/100ps
`default_nettype none
interface div_if;
	import smoothing_filter_pkg::*;
	logic start;
	logic signed [NUM_W-1:0] num;
	logic [DEN_W-1:0] den;
	logic done;
	logic signed [NUM_W-1:0] quot;
	modport requester (output start, num, den, input done, quot);
	modport divider (input start, num, den, output done, quot);
endinterface
`default_nettype wire

// File: rtl/serial_divider.sv
// Serial signed divider, one quotient bit per clock, truncates toward zero
`timescale 1ns/100ps
`default_nettype none
module serial_divider import smoothing_filter_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Division port
	div_if.divider dv
);
	logic [NUM_W-1:0] mag;
	logic [DEN_W-1:0] rem;
	logic [DEN_W-1:0] den;
	logic neg;
	logic busy;
	logic [6:0] cnt;
	logic [DEN_W:0] shifted;
	logic [DEN_W+1:0] trial;

	always_comb begin
		shifted = {rem, mag[NUM_W-1]};
		trial = {1'b0, shifted} - {2'b00, den};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= 7'h00;
			dv.done <= 1'b0;
			mag <= '0;
			rem <= '0;
			den <= '0;
			neg <= 1'b0;
		end else begin
			dv.done <= 1'b0;
			if (dv.start && !busy) begin
				busy <= 1'b1;
				cnt <= 7'(NUM_W);
				neg <= dv.num[NUM_W-1];
				mag <= dv.num[NUM_W-1] ? NUM_W'(-dv.num) : NUM_W'(dv.num);
				rem <= '0;
				den <= dv.den;
			end else if (busy) begin
				// Restoring step: keep remainder when the trial borrows
				if (trial[DEN_W+1]) begin
					rem <= shifted[DEN_W-1:0];
					mag <= {mag[NUM_W-2:0], 1'b0};
				end else begin
					rem <= trial[DEN_W-1:0];
					mag <= {mag[NUM_W-2:0], 1'b1};
				end
				cnt <= cnt - 7'h01;
				if (cnt == 7'h01) begin
					busy <= 1'b0;
					dv.done <= 1'b1;
				end
			end
		end
	end

	assign dv.quot = neg ? -$signed(mag) : $signed(mag);
endmodule
`default_nettype wire

// File: rtl/smoothing_filter_block.sv
// Smoothing filter array: per-channel low-pass filters behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: Each channel low-pass filters its input so output follows slow changes only.
// R2: Thirty-two independent channels, each with enable, input, time, gain, output.
// R3: Enable low resets the channel and forces its output to zero.
// R4: Input is a signed 16-bit integer.
// R5: Output is a signed 16-bit integer.
// R6: Recovery time is unsigned 16-bit, one unit per 100 ms.
// R7: Input is scaled by gain in percent; 100 means factor one.
// R8: First evaluation after reset or enable loads output with the raw input.
// R9: Each scan adds scan/recovery ratio times (scaled input minus output).
// R10: Step response is exponential, reaching 0.63 after one recovery time.
// R11: Scan is 10 ms up to 1 s recovery, else recovery times 0.01.
// R12: Scan is a whole number of program cycles, rounded up.
// R13: Configuring party picks scan near ten program cycles or an exact multiple.
// R14: Configuring party keeps recovery time no longer than needed.
// R15: Output is presented as a whole integer, no fraction exposed.
// R16: Results saturate to the signed 16-bit range instead of wrapping.
// R17: Scan tick comes from free-running counters of whole program cycles.
module smoothing_filter_block import smoothing_filter_pkg::*; #(
	parameter int unsigned CHANNELS = 32,
	parameter int unsigned CYCLE_MS = 1,
	parameter int unsigned CYCLE_CLKS = CYCLE_MS * CLKS_PER_MS
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [8:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [8:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Filtered outputs, channel c at bits [16c+15:16c]
	output logic [CHANNELS*16-1:0] filtered_output
);
	localparam int unsigned PTR_W = $clog2(CHANNELS);
	localparam logic signed [NUM_W:0] SAT_HI = (NUM_W+1)'(ACC_MAX);
	localparam logic signed [NUM_W:0] SAT_LO = (NUM_W+1)'(ACC_MIN);

	initial begin
		if (CHANNELS < 2 || CHANNELS > 32)
			$error("smoothing_filter_block: CHANNELS must be 2..32");
		if (CYCLE_MS < 1 || CYCLE_MS > 255)
			$error("smoothing_filter_block: CYCLE_MS must be 1..255");
	end

	// Scan period in program cycles, rounded up to a whole cycle count
	function automatic logic [15:0] scan_cycles(input logic [15:0] rec);
		logic [31:0] ms;
		ms = (32'(rec) <= SHORT_REC_MAX) ? 32'(SHORT_SCAN_MS)
			: 32'(rec) * REC_UNIT_MS / SCAN_PER_REC; // [R11]
		return 16'((ms + CYCLE_MS - 1) / CYCLE_MS); // [R12]
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (s[b])
				r[8*b +: 8] = d[8*b +: 8];
		end
		return r;
	endfunction

	// =====================================================
	// Channel storage
	logic [31:0] cfg [CHANNELS];
	logic [16:0] inreg [CHANNELS];
	logic signed [31:0] acc [CHANNELS];
	logic [15:0] out_word [CHANNELS];
	logic [CHANNELS-1:0] en;
	logic [CHANNELS-1:0] pend;
	logic [CHANNELS-1:0] first;
	logic prog_tick;
	logic stored;
	calc_state_t state;
	logic [PTR_W-1:0] ptr;
	logic [PTR_W-1:0] cur;
	logic direct_q;
	div_if dv();

	cycle_tick #(.PERIOD(CYCLE_CLKS)) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(prog_tick)
	);

	serial_divider u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.dv(dv)
	);

	// =====================================================
	// Per-channel scan counters
	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch // [R2]
		logic [15:0] cnt;
		logic [15:0] n;
		logic wrap;
		logic pend_r;
		logic first_r;
		assign en[c] = inreg[c][ENABLE_BIT];
		assign pend[c] = pend_r;
		assign first[c] = first_r;
		assign filtered_output[16*c +: 16] = out_word[c];
		always_comb begin
			n = scan_cycles(cfg[c][15:0]);
			wrap = (cnt + 16'h0001 >= n);
		end
		always_ff @(posedge aclk) begin
			if (!aresetn || !en[c]) begin // [R3]
				cnt <= 16'h0000;
				pend_r <= 1'b0;
				first_r <= 1'b1;
			end else begin
				if (prog_tick)
					cnt <= wrap ? 16'h0000 : cnt + 16'h0001; // [R17]
				if (prog_tick && wrap)
					pend_r <= 1'b1;
				else if (stored && cur == PTR_W'(c))
					pend_r <= 1'b0;
				if (stored && cur == PTR_W'(c))
					first_r <= 1'b0;
			end
		end
	end

	// =====================================================
	// Step computation for the channel under the pointer
	logic go;
	logic [15:0] rec_p;
	logic signed [32:0] prod;
	logic signed [NUM_W-1:0] target;
	logic signed [NUM_W-1:0] seed;
	logic signed [NUM_W-1:0] diff;
	logic [23:0] m;
	logic direct_n;

	always_comb begin
		rec_p = cfg[ptr][15:0]; // [R6]
		go = en[ptr] && (pend[ptr] || first[ptr]);
		prod = $signed(inreg[ptr][15:0]) * $signed({1'b0, cfg[ptr][31:GAIN_LSB]}); // [R4] [R7]
		target = NUM_W'(prod) <<< FRAC_W;
		// Unscaled raw input, times 100 so it shares the divide by 100
		seed = NUM_W'(24'($signed(inreg[ptr][15:0])) * $signed(24'(UNITY_GAIN))) <<< FRAC_W; // [R8]
		m = 24'(scan_cycles(rec_p)) * 24'(CYCLE_MS);
		// Scan at least as long as recovery time collapses to a direct load
		direct_n = first[ptr] || (32'(m) >= 32'(rec_p) * REC_UNIT_MS); // [R8]
		diff = target - NUM_W'(acc[ptr]) * $signed({1'b0, 7'(UNITY_GAIN)});
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			ptr <= '0;
			cur <= '0;
			direct_q <= 1'b0;
			dv.start <= 1'b0;
			dv.num <= '0;
			dv.den <= '0;
		end else begin
			dv.start <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					ptr <= (ptr == PTR_W'(CHANNELS - 1)) ? '0 : ptr + PTR_W'(1);
					if (go) begin
						cur <= ptr;
						direct_q <= direct_n;
						dv.start <= 1'b1;
						state <= ST_CALC;
						if (direct_n) begin
							dv.num <= first[ptr] ? seed : target; // [R8]
							dv.den <= DEN_W'(UNITY_GAIN);
						end else begin
							// out += (gain * in - out) * scan / recovery, scaled by 100 for percent gain
							dv.num <= NUM_W'(diff * $signed({1'b0, m})); // [R9] [R1] [R10]
							dv.den <= DEN_W'(rec_p) * DEN_W'(REC_UNIT_MS * UNITY_GAIN);
						end
					end
				end
				ST_CALC: begin
					if (dv.done)
						state <= ST_IDLE;
				end
			endcase
		end
	end

	// =====================================================
	// Accumulator update with saturation
	logic signed [NUM_W:0] base;
	logic signed [NUM_W:0] sum;
	logic signed [31:0] acc_new;

	assign stored = (state == ST_CALC) && dv.done;

	always_comb begin
		base = direct_q ? '0 : (NUM_W+1)'(acc[cur]);
		sum = base + (NUM_W+1)'(dv.quot);
		if (sum > SAT_HI)
			acc_new = ACC_MAX; // [R16]
		else if (sum < SAT_LO)
			acc_new = ACC_MIN; // [R16]
		else
			acc_new = 32'(sum);
	end

	always_ff @(posedge aclk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (!aresetn || !en[c]) begin
				acc[c] <= 32'sh0000_0000; // [R3]
				out_word[c] <= 16'h0000;
			end else if (stored && cur == PTR_W'(c)) begin
				acc[c] <= acc_new;
				out_word[c] <= acc_new[31:16]; // [R15] [R5]
			end
		end
	end

	// =====================================================
	// AXI4-Lite slave
	logic aw_take;
	logic aw_hs;
	logic ar_hs;
	logic [4:0] wch;
	logic [4:0] rch;
	logic w_ok;

	always_comb begin
		aw_take = awvalid && wvalid && !awready && !bvalid;
		aw_hs = awvalid && awready && wvalid && wready;
		ar_hs = arvalid && arready;
		wch = awaddr[7:3];
		rch = araddr[REGION_BIT] ? araddr[6:2] : araddr[7:3];
		w_ok = !awaddr[REGION_BIT] && (32'(wch) < CHANNELS);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			for (int c = 0; c < CHANNELS; c++) begin
				cfg[c] <= CFG_RESET;
				inreg[c] <= IN_RESET;
			end
		end else begin
			awready <= aw_take;
			wready <= aw_take;
			if (bvalid && bready)
				bvalid <= 1'b0;
			if (aw_hs) begin
				bvalid <= 1'b1;
				bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
				if (w_ok && awaddr[FIELD_BIT] == IN_BASE[FIELD_BIT])
					inreg[PTR_W'(wch)] <= 17'(apply_strb(32'(inreg[PTR_W'(wch)]), wdata, wstrb));
				else if (w_ok)
					cfg[PTR_W'(wch)] <= apply_strb(cfg[PTR_W'(wch)], wdata, wstrb);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else begin
			arready <= arvalid && !arready && !rvalid;
			if (rvalid && rready)
				rvalid <= 1'b0;
			if (ar_hs) begin
				rvalid <= 1'b1;
				rdata <= 32'h0000_0000;
				rresp <= RESP_OKAY;
				if (32'(rch) >= CHANNELS || (araddr[REGION_BIT] && araddr[7]))
					rresp <= RESP_SLVERR;
				else if (araddr[REGION_BIT] == OUT_BASE[REGION_BIT])
					rdata <= {16'h0000, out_word[PTR_W'(rch)]};
				else if (araddr[FIELD_BIT] == IN_BASE[FIELD_BIT])
					rdata <= 32'(inreg[PTR_W'(rch)]);
				else
					rdata <= cfg[PTR_W'(rch)];
			end
		end
	end

	// =====================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_en_zero;
		!en[0] |=> out_word[0] == 16'h0000 && acc[0] == 32'sh0000_0000;
	endproperty
	a_en_zero: assert property (p_en_zero) else $error("disabled channel output not zero"); // [R3]

	property p_int_out;
		stored && en[cur] |=> out_word[$past(cur)] == acc[$past(cur)][31:16];
	endproperty
	a_int_out: assert property (p_int_out) else $error("output not integer part of state"); // [R15]

	property p_preload;
		state == ST_IDLE && go && first[ptr] |=> direct_q && dv.den == DEN_W'(UNITY_GAIN) && dv.start;
	endproperty
	a_preload: assert property (p_preload) else $error("first evaluation not a preload"); // [R8]

	property p_scan_wrap;
		prog_tick && en[0] && g_ch[0].wrap |=> pend[0] && g_ch[0].cnt == 16'h0000;
	endproperty
	a_scan_wrap: assert property (p_scan_wrap) else $error("scan period end not flagged"); // [R11]

	property p_scan_on_cycle;
		$rose(pend[0]) |-> $past(prog_tick);
	endproperty
	a_scan_on_cycle: assert property (p_scan_on_cycle) else $error("scan outside program cycle"); // [R12]

	property p_div_time;
		dv.start |-> ##[1:80] dv.done;
	endproperty
	a_div_time: assert property (p_div_time) else $error("step computation too slow"); // [R9]

	property p_sat_hi;
		stored && en[cur] && sum > SAT_HI |=> acc[$past(cur)] == ACC_MAX;
	endproperty
	a_sat_hi: assert property (p_sat_hi) else $error("positive overflow not saturated"); // [R16]

	property p_write_resp;
		aw_hs |=> bvalid;
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write response missing");

	property p_read_resp;
		ar_hs |=> rvalid;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("read response missing");

	c_preload: cover property (stored && direct_q && en[cur]);
	c_update: cover property (stored && !direct_q && en[cur]);
	c_saturate: cover property (stored && sum > SAT_HI);
endmodule
`default_nettype wire

// File: rtl/smoothing_filter_pkg.sv
// Package: constants and types of the smoothing filter array
`default_nettype none
package smoothing_filter_pkg;
	// =====================================================
	// Timing
	localparam int unsigned CLK_KHZ = 40000;
	localparam int unsigned CLKS_PER_MS = CLK_KHZ;
	localparam int unsigned REC_UNIT_MS = 100;
	localparam int unsigned SHORT_SCAN_MS = 10;
	localparam int unsigned SHORT_REC_MAX = 10;
	localparam int unsigned SCAN_PER_REC = 100;
	// =====================================================
	// Arithmetic
	localparam int unsigned UNITY_GAIN = 100;
	localparam int unsigned FRAC_W = 16;
	localparam int unsigned NUM_W = 76;
	localparam int unsigned DEN_W = 30;
	localparam logic signed [31:0] ACC_MAX = 32'sh7fff_ffff;
	localparam logic signed [31:0] ACC_MIN = 32'sh8000_0000;
	// =====================================================
	// Register map
	localparam logic [8:0] CFG_BASE = 9'h000;
	localparam logic [8:0] IN_BASE = 9'h004;
	localparam logic [8:0] OUT_BASE = 9'h100;
	localparam int unsigned REGION_BIT = 8;
	localparam int unsigned FIELD_BIT = 2;
	localparam int unsigned GAIN_LSB = 16;
	localparam int unsigned ENABLE_BIT = 16;
	localparam logic [31:0] CFG_RESET = 32'h0064_000a;
	localparam logic [16:0] IN_RESET = 17'h0_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic {ST_IDLE, ST_CALC} calc_state_t;
endpackage
`default_nettype wire
